// >>> hdl/system_state_controller.v
// System reset and clock sequencer with AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "sysctl_regs.vh"
module system_state_controller (
   input wire aclk,
   input wire aresetn,
   input wire power_on_pulse,
   input wire low_voltage_in,
   input wire watchdog_overflow,
   input wire irq_test_voltage,
   input wire bad_opcode_in,
   input wire stop_instr,
   input wire wait_instr,
   input wire opcode_fetch,
   input wire unmapped_access,
   input wire monitor_entry_reset,
   input wire wake_event,
   input wire reset_pin_in,
   output reg reset_pin_out,
   output reg reset_pin_oe,
   output reg internal_reset,
   output reg [15:0] reset_vector,
   output reg half_osc_clock,
   output reg cpu_clock,
   output reg periph_clock,
   output reg osc_enable,
   output reg watchdog_enable,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   localparam S_RUN = 7'b0000001;
   localparam S_LONG = 7'b0000010;
   localparam S_PIN = 7'b0000100;
   localparam S_HOLD = 7'b0001000;
   localparam S_STOP = 7'b0010000;
   localparam S_WAIT = 7'b0100000;
   localparam S_WAKE = 7'b1000000;
   reg [6:0] state;
   reg [12:0] counter;
   reg [6:0] reset_cause_register;
   reg [2:0] ctrl;
   reg pin_s1;
   reg pin_s2;
   reg wdog_s1;
   reg wdog_s2;
   reg [12:0] pin_low_cnt;
   reg long_origin;
   reg phase;
   reg [1:0] div;
   reg aw_held;
   reg w_held;
   reg [3:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire stop_illegal = stop_instr & ~ctrl[`CTRL_STOPEN];
   wire opc_evt = bad_opcode_in | stop_illegal;
   wire adr_evt = unmapped_access & opcode_fetch;
   wire wdog_evt = wdog_s2 & ~(irq_test_voltage & ctrl[`CTRL_MON]);
   wire short_evt = opc_evt | adr_evt | wdog_evt | monitor_entry_reset;
   wire long_evt = power_on_pulse | low_voltage_in;
   wire pin_low = ~pin_s2;
   wire busy = (state == S_LONG) | (state == S_PIN) | (state == S_HOLD);
   wire read_cause = s_axi_rvalid & s_axi_rready & phase;
   wire [12:0] pin_need = long_origin ? `PIN_LONG_CYC : `PIN_SHORT_CYC;
   // Synchronisers for asynchronous pin and watchdog
   always @(posedge aclk) begin
      pin_s1 <= reset_pin_in;
      pin_s2 <= pin_s1;
      wdog_s1 <= watchdog_overflow;
      wdog_s2 <= wdog_s1;
   end
   // Reset sequencer
   always @(posedge aclk) begin
      if (!aresetn || power_on_pulse) begin
         state <= S_LONG;
         counter <= 13'h0000;
         reset_pin_out <= 1'b0;
         reset_pin_oe <= 1'b1;
         internal_reset <= 1'b1;
         long_origin <= 1'b1;
         osc_enable <= 1'b1;
      end else if (low_voltage_in) begin
         state <= S_LONG;
         counter <= 13'h0000;
         reset_pin_oe <= 1'b1;
         internal_reset <= 1'b1;
         long_origin <= 1'b1;
      end else if (short_evt && !busy) begin
         state <= S_PIN;
         counter <= 13'h0000;
         reset_pin_oe <= 1'b1;
         internal_reset <= 1'b1;
         long_origin <= 1'b0;
      end else begin
         reset_pin_out <= 1'b0;
         case (state)
            S_LONG: begin
               counter <= counter + 13'h0001;
               if (counter == `LONG_CYC + `SHORT_CYC - 13'h0001) begin
                  state <= S_HOLD;
                  counter <= 13'h0000;
                  reset_pin_oe <= 1'b0;
               end
            end
            S_PIN: begin
               counter <= counter + 13'h0001;
               if (counter == `SHORT_CYC - 13'h0001) begin
                  state <= S_HOLD;
                  counter <= 13'h0000;
                  reset_pin_oe <= 1'b0;
               end
            end
            S_HOLD: begin
               counter <= counter + 13'h0001;
               if (counter >= `SHORT_CYC - 13'h0001 && !pin_low) begin
                  state <= S_RUN;
                  internal_reset <= 1'b0;
               end
            end
            S_STOP: begin
               if (wake_event || pin_low) begin
                  state <= S_WAKE;
                  counter <= 13'h0000;
               end
            end
            S_WAKE: begin
               counter <= counter + 13'h0001;
               if (counter == (ctrl[`CTRL_SHORT_STOP_RECOVERY_OPTION] ? `SHORT_CYC : `LONG_CYC) - 13'h0001) begin
                  state <= S_RUN;
               end
            end
            S_WAIT: begin
               if (wake_event) begin
                  state <= S_RUN;
               end
            end
            default: begin
               counter <= counter + 13'h0001;
               if (pin_low) begin
                  internal_reset <= 1'b1;
               end else if (internal_reset) begin
                  internal_reset <= 1'b0;
               end else if (stop_instr && ctrl[`CTRL_STOPEN]) begin
                  state <= S_STOP;
                  counter <= 13'h0000;
               end else if (wait_instr) begin
                  state <= S_WAIT;
               end
            end
         endcase
      end
   end
   // Pin low duration and cause flags
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_low_cnt <= 13'h0000;
         reset_cause_register <= 7'h01;
      end else if (power_on_pulse) begin
         pin_low_cnt <= 13'h0000;
         reset_cause_register <= 7'h01;
      end else begin
         if (pin_low && !reset_pin_oe && pin_low_cnt != 13'h1FFF) begin
            pin_low_cnt <= pin_low_cnt + 13'h0001;
         end else if (!pin_low) begin
            pin_low_cnt <= 13'h0000;
         end
         if (read_cause) begin
            reset_cause_register <= 7'h00;
         end
         if (pin_low_cnt == pin_need) begin
            reset_cause_register[`BIT_PIN] <= 1'b1;
         end
         if (wdog_evt) begin
            reset_cause_register[`BIT_WDOG] <= 1'b1;
         end
         if (opc_evt) begin
            reset_cause_register[`BIT_OPC] <= 1'b1;
         end
         if (adr_evt) begin
            reset_cause_register[`BIT_ADR] <= 1'b1;
         end
         if (monitor_entry_reset) begin
            reset_cause_register[`BIT_MON] <= 1'b1;
         end
         if (low_voltage_in) begin
            reset_cause_register[`BIT_LOW] <= 1'b1;
         end
      end
   end
   // Clock division and gating
   always @(posedge aclk) begin
      if (!aresetn) begin
         div <= 2'h0;
         half_osc_clock <= 1'b0;
         cpu_clock <= 1'b0;
         periph_clock <= 1'b0;
         watchdog_enable <= 1'b0;
         reset_vector <= `VEC_NORMAL;
      end else begin
         div <= div + 2'h1;
         half_osc_clock <= ~div[0];
         cpu_clock <= ~div[1] & (state == S_RUN) & ~internal_reset;
         periph_clock <= ~div[1] & ((state == S_RUN) | (state == S_WAIT));
         watchdog_enable <= ~(irq_test_voltage & ctrl[`CTRL_MON]);
         reset_vector <= ctrl[`CTRL_MON] ? `VEC_MONITOR : `VEC_NORMAL;
      end
   end
   // AXI4-Lite slave
   always @(posedge aclk) begin
      if (!aresetn || (internal_reset && state != S_RUN)) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OK;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OK;
         ctrl <= 3'h0;
         phase <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
         s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_held && w_held && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            if (aw_addr == `OFS_CTRL) begin
               s_axi_bresp <= `RESP_OK;
               if (w_strb[0]) begin
                  ctrl <= w_data[2:0];
               end
            end else if (aw_addr == `OFS_CAUSE || aw_addr == `OFS_STATUS) begin
               s_axi_bresp <= `RESP_OK;
            end else begin
               s_axi_bresp <= `RESP_ERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= ~s_axi_arready & s_axi_arvalid & ~s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            phase <= (s_axi_araddr == `OFS_CAUSE);
            s_axi_rresp <= `RESP_OK;
            case (s_axi_araddr)
               `OFS_CAUSE: s_axi_rdata <= {25'h0000000, reset_cause_register};
               `OFS_CTRL: s_axi_rdata <= {29'h00000000, ctrl};
               `OFS_STATUS: s_axi_rdata <= {25'h0000000, state};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `RESP_ERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            phase <= 1'b0;
         end
      end
   end
endmodule

// >>> include/sysctl_regs.vh
// Register offsets, field positions and timing counts of the system state controller
`ifndef SYSCTL_REGS_VH
`define SYSCTL_REGS_VH
`define OFS_CAUSE 4'h0
`define OFS_CTRL 4'h4
`define OFS_STATUS 4'h8
`define BIT_POR 0
`define BIT_PIN 1
`define BIT_WDOG 2
`define BIT_OPC 3
`define BIT_ADR 4
`define BIT_MON 5
`define BIT_LOW 6
`define CTRL_SHORT_STOP_RECOVERY_OPTION 0
`define CTRL_STOPEN 1
`define CTRL_MON 2
`define LONG_CYC 13'h1000
`define SHORT_CYC 13'h0020
`define PIN_SHORT_CYC 13'h0043
`define PIN_LONG_CYC 13'h1043
`define VEC_NORMAL 16'hFFFE
`define VEC_MONITOR 16'hFEFE
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// >>> tb/reset_pin_model.sv
// Reset pin circuit model: pullup, open-drain device and external pull
`timescale 1ns/1ps
module reset_pin_model (
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic ext_pull,
   output logic reset_pin_in
);
   // Pullup holds high unless a party pulls low
   assign reset_pin_in = ((reset_pin_oe && !reset_pin_out) || ext_pull) ? 1'b0 : 1'b1;
endmodule

// >>> tb/system_reset_clock_sequencer_tb.sv
// Self-checking bench for the system state controller
`timescale 1ns/1ps
`include "sysctl_regs.vh"
module system_reset_clock_sequencer_tb;
   logic aclk = 1'b0, aresetn = 1'b0, dacc = 1'b0, irq_tv = 1'b0, wait_instr = 1'b0;
   logic wake_event = 1'b0, cs, ps;
   logic [7:0] src = 8'h00;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire reset_pin_in, reset_pin_out, reset_pin_oe, internal_reset, half_osc_clock;
   wire cpu_clock, periph_clock, osc_enable, watchdog_enable;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [15:0] reset_vector;
   wire [31:0] s_axi_rdata;
   logic [33:0] exp_q[$];
   int n_fail = 0, check_count = 0, seed = 32'h83B0, k;
   int bits[8] = '{`BIT_WDOG, `BIT_PIN, `BIT_OPC, `BIT_OPC, `BIT_ADR, `BIT_MON, `BIT_LOW,
      `BIT_POR};
   system_state_controller i_dut (.aclk, .aresetn, .power_on_pulse(src[7]),
      .low_voltage_in(src[6]), .watchdog_overflow(src[0]), .irq_test_voltage(irq_tv),
      .bad_opcode_in(src[2]), .stop_instr(src[3]), .wait_instr, .opcode_fetch(src[4]),
      .unmapped_access(src[4] | dacc), .monitor_entry_reset(src[5]), .wake_event,
      .reset_pin_in, .reset_pin_out, .reset_pin_oe, .internal_reset, .reset_vector,
      .half_osc_clock, .cpu_clock, .periph_clock, .osc_enable, .watchdog_enable,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   reset_pin_model i_pin (.reset_pin_out, .reset_pin_oe, .ext_pull(src[1]), .reset_pin_in);
   task test_done;
      $display("checks %0d errors %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [33:0] got, input logic [33:0] e);
      check_count++;
      if (got !== e) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, e);
      end
   endtask
   task to(input int i, input int n);
      if (i >= n) begin
         n_fail++;
         test_done();
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready)
         chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      if (s_axi_bvalid === 1'b1 && s_axi_bready)
         chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
   end
   task rd(input logic [3:0] a, input logic [33:0] e);
      int i;
      exp_q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      to(i, 50);
      tick(1);
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      int i;
      exp_q.push_back({`RESP_OK, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      to(i, 50);
      tick(1);
   endtask
   task wt(input logic lvl, input int n);
      int i;
      for (i = 0; i < n && internal_reset !== lvl; i++) @(posedge aclk);
      to(i, n);
   endtask
   task fire(input int s);
      src[s] <= 1'b1;
      wt(1'b1, 200);
      tick(s == 1 ? 70 + ($random(seed) & 15) : 0);
      src[s] <= 1'b0;
      wt(1'b0, 6000);
      tick(2);
   endtask
   initial forever #4 aclk = ~aclk;
   initial begin
      tick(3);
      aresetn <= 1'b1;
      wt(1'b0, 6000);
      tick(2);
      chk({18'h0, reset_vector}, {18'h0, `VEC_NORMAL});
      chk({33'h0, osc_enable}, 34'h1);
      cs = half_osc_clock;
      @(posedge aclk);
      chk({33'h0, half_osc_clock ^ cs}, 34'h1);
      rd(`OFS_CAUSE, 34'h1);
      rd(`OFS_CAUSE, 34'h0);
      for (k = 0; k < 8; k++) begin
         fire(k);
         rd(`OFS_CAUSE, 34'h1 << bits[k]);
      end
      fire(0);
      fire(2);
      rd(`OFS_CAUSE, (34'h1 << `BIT_WDOG) | (34'h1 << `BIT_OPC));
      dacc <= 1'b1;
      tick(4);
      dacc <= 1'b0;
      tick(10);
      chk({33'h0, internal_reset}, 34'h0);
      rd(`OFS_CAUSE, 34'h0);
      wait_instr <= 1'b1;
      tick(1);
      wait_instr <= 1'b0;
      tick(4);
      cs = 1'b0;
      ps = 1'b0;
      repeat (16) begin
         @(posedge aclk);
         cs = cs | cpu_clock;
         ps = ps | periph_clock;
      end
      chk({32'h0, cs, ps}, 34'h1);
      wake_event <= 1'b1;
      tick(1);
      wake_event <= 1'b0;
      wr(`OFS_CTRL, 32'h2);
      rd(`OFS_CTRL, 34'h2);
      rd(4'hC, {`RESP_ERR, 32'h0});
      wr(`OFS_CTRL, 32'h3);
      src[3] <= 1'b1;
      tick(1);
      src[3] <= 1'b0;
      tick(3);
      rd(`OFS_STATUS, 34'h10);
      wake_event <= 1'b1;
      tick(1);
      wake_event <= 1'b0;
      tick(2);
      rd(`OFS_STATUS, 34'h40);
      chk({33'h0, cpu_clock}, 34'h0);
      tick(40);
      rd(`OFS_STATUS, 34'h1);
      wr(`OFS_CTRL, 32'h4);
      irq_tv <= 1'b1;
      tick(3);
      chk({18'h0, reset_vector}, {18'h0, `VEC_MONITOR});
      chk({33'h0, watchdog_enable}, 34'h0);
      irq_tv <= 1'b0;
      tick(3);
      chk({33'h0, watchdog_enable}, 34'h1);
      test_done();
   end
endmodule

// >>> tb/system_state_controller_sva.sv
// Assertion checker for the system state controller ports
`timescale 1ns/1ps
`include "sysctl_regs.vh"
module system_state_controller_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic internal_reset,
   input wire logic [15:0] reset_vector,
   input wire logic cpu_clock,
   input wire logic periph_clock,
   input wire logic watchdog_enable,
   input wire logic watchdog_overflow,
   input wire logic bad_opcode_in,
   input wire logic opcode_fetch,
   input wire logic unmapped_access
);
   logic [12:0] oe_cnt;
   logic [6:0] tail_cnt;
   always @(posedge aclk) begin
      if (!aresetn || !reset_pin_oe)
         oe_cnt <= 13'h0000;
      else
         oe_cnt <= oe_cnt + 13'h0001;
      if (reset_pin_oe || !internal_reset)
         tail_cnt <= 7'h00;
      else if (tail_cnt != 7'h7F)
         tail_cnt <= tail_cnt + 7'h01;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_rst_soon;
      ##[1:8] reset_pin_oe;
   endsequence
   property p_od; reset_pin_oe |-> !reset_pin_out; endproperty
   a_od: assert property (p_od) else $error("reset pin driven high");
   property p_clk_off;
      reset_pin_oe && $past(reset_pin_oe) |-> !cpu_clock && !periph_clock;
   endproperty
   a_clk_off: assert property (p_clk_off) else $error("clocks run in reset");
   property p_len;
      $fell(reset_pin_oe) |-> oe_cnt inside {[31:33], [4127:4129]};
   endproperty
   a_len: assert property (p_len) else $error("pin low length wrong");
   property p_tail; $fell(internal_reset) |-> tail_cnt >= 32; endproperty
   a_tail: assert property (p_tail) else $error("reset tail too short");
   property p_vec;
      $fell(internal_reset) |-> reset_vector inside {`VEC_NORMAL, `VEC_MONITOR};
   endproperty
   a_vec: assert property (p_vec) else $error("bad reset vector");
   property p_opc; $rose(bad_opcode_in) && !internal_reset |-> s_rst_soon; endproperty
   a_opc: assert property (p_opc) else $error("no opcode reset");
   property p_adr;
      opcode_fetch && unmapped_access && !internal_reset |-> s_rst_soon;
   endproperty
   a_adr: assert property (p_adr) else $error("no address reset");
   property p_wdog;
      $rose(watchdog_overflow) && watchdog_enable && !internal_reset |-> s_rst_soon;
   endproperty
   a_wdog: assert property (p_wdog) else $error("no watchdog reset");
endmodule
bind system_state_controller system_state_controller_sva i_sva (.aclk, .aresetn,
   .reset_pin_out, .reset_pin_oe, .internal_reset, .reset_vector, .cpu_clock,
   .periph_clock, .watchdog_enable, .watchdog_overflow, .bad_opcode_in, .opcode_fetch,
   .unmapped_access);
